/* inc/apdc_consts.svh */
`ifndef APDC_CONSTS_SVH
`define APDC_CONSTS_SVH

// System clock and prescaled tick
`define APDC_CLK_HZ        10000000
`define APDC_TICK_US       1000
`define APDC_TICK_CYC      (`APDC_CLK_HZ / 1000000 * `APDC_TICK_US)
`define APDC_TICKS_PER_S   (1000000 / `APDC_TICK_US)

// Idle window before power-down
`define APDC_IDLE_MIN      15
`define APDC_IDLE_TICKS    (`APDC_IDLE_MIN * 60 * `APDC_TICKS_PER_S)

// Measurement rate in tenths of reports per second; interval rounds down
`define APDC_MEAS_RATE_X10 65
`define APDC_MEAS_TICKS    (`APDC_TICKS_PER_S * 10 / `APDC_MEAS_RATE_X10)

// Battery report period
`define APDC_BATT_S        60
`define APDC_BATT_TICKS    (`APDC_BATT_S * `APDC_TICKS_PER_S)

// Calibration table
`define APDC_NUM_RANGES    6
`define APDC_GAIN_MILLI    32'h3a83126f
`define APDC_GAIN_UNIT     32'h3f800000
`define APDC_GAIN_MICRO    32'h358637bd
`define APDC_CAL_ZERO      32'h00000000

`endif

/* inc/apdc_pkg.sv */
package apdc_pkg;

    typedef enum logic [2:0]
    {
        APDC_ST_ADV  = 3'b001,
        APDC_ST_CONN = 3'b010,
        APDC_ST_DOWN = 3'b100
    } apdc_state_t;

    typedef enum logic [2:0]
    {
        APDC_K_MEAS_DC = 3'h0,
        APDC_K_MEAS_AC = 3'h1,
        APDC_K_BATT    = 3'h2,
        APDC_K_SWITCH  = 3'h3,
        APDC_K_TOUCH   = 3'h4,
        APDC_K_NFC     = 3'h5,
        APDC_K_STATUS  = 3'h6
    } apdc_kind_t;

    localparam int APDC_NUM_KINDS = 7;

endpackage

/* logic/apdc_cal_store.sv */
`timescale 1ns/1ps
`include "apdc_consts.svh"

module apdc_cal_store #(
    parameter int NR = `APDC_NUM_RANGES
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        we_i,
    input  wire logic [2:0]  widx_i,
    input  wire logic [31:0] wgain_i,
    input  wire logic [31:0] woff_i,
    input  wire logic [31:0] wnoise_i,
    input  wire logic [2:0]  ridx_i,
    output logic      [31:0] rgain_o,
    output logic      [31:0] roff_o,
    output logic      [31:0] rnoise_o
);
    logic [95:0] tab_r [NR];

    function automatic logic [31:0] apdc_def_gain(input int i);
        case (i)
            2, 3:    apdc_def_gain = `APDC_GAIN_UNIT;
            5:       apdc_def_gain = `APDC_GAIN_MICRO;
            default: apdc_def_gain = `APDC_GAIN_MILLI;
        endcase
    endfunction

    always_ff @(posedge core_clk_i)
    begin
        for (int i = 0; i < NR; i++)
        begin
            if (rst_i)
                tab_r[i] <= {apdc_def_gain(i), `APDC_CAL_ZERO, `APDC_CAL_ZERO};
            else if (we_i && (int'(widx_i) == i))
                tab_r[i] <= {wgain_i, woff_i, wnoise_i};
        end
    end

    // Unused codes above the last range read as zero
    always_comb
    begin
        if (int'(ridx_i) < NR)
        begin
            rgain_o  = tab_r[ridx_i][95:64];
            roff_o   = tab_r[ridx_i][63:32];
            rnoise_o = tab_r[ridx_i][31:0];
        end
        else
        begin
            rgain_o  = `APDC_CAL_ZERO;
            roff_o   = `APDC_CAL_ZERO;
            rnoise_o = `APDC_CAL_ZERO;
        end
    end
endmodule

/* logic/apdc_top.sv */
`timescale 1ns/1ps
`include "apdc_consts.svh"

module apdc_top #(
    parameter int TICK_CYC   = `APDC_TICK_CYC,
    parameter int IDLE_TICKS = `APDC_IDLE_TICKS,
    parameter int MEAS_TICKS = `APDC_MEAS_TICKS,
    parameter int BATT_TICKS = `APDC_BATT_TICKS
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        touch_i,
    input  wire logic [1:0]  vrange_sw_i,
    input  wire logic        mode_sw_i,
    input  wire logic        conn_up_i,
    input  wire logic        nfc_evt_i,
    input  wire logic [31:0] meas_dc_i,
    input  wire logic [31:0] meas_ac_i,
    input  wire logic [7:0]  batt_soc_i,
    input  wire logic [15:0] batt_mv_i,
    input  wire logic        host_range_we_i,
    input  wire logic [2:0]  host_range_i,
    input  wire logic        cal_we_i,
    input  wire logic [2:0]  cal_idx_i,
    input  wire logic [31:0] cal_gain_i,
    input  wire logic [31:0] cal_off_i,
    input  wire logic [31:0] cal_noise_i,
    output logic             adv_en_o,
    output logic             conn_accept_o,
    output logic             pwr_down_o,
    output logic             connected_o,
    output logic             rpt_valid_o,
    output logic [2:0]       rpt_kind_o,
    output logic [31:0]      rpt_data_o,
    output logic [2:0]       range_sel_o,
    output logic [31:0]      cal_gain_o,
    output logic [31:0]      cal_off_o,
    output logic [31:0]      cal_noise_o
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam int IW = $clog2(IDLE_TICKS + 1);
    localparam int MW = $clog2(MEAS_TICKS + 1);
    localparam int BW = $clog2(BATT_TICKS + 1);
    localparam int NK = apdc_pkg::APDC_NUM_KINDS;
    localparam logic [PW-1:0] PRE_LAST  = PW'(TICK_CYC - 1);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_TICKS - 1);
    localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_TICKS - 1);
    localparam logic [BW-1:0] BATT_LAST = BW'(BATT_TICKS - 1);

    typedef struct packed {
        apdc_pkg::apdc_state_t st;
        logic [PW-1:0]         pre;
        logic [IW-1:0]         idle;
        logic [MW-1:0]         meas;
        logic [BW-1:0]         batt;
        logic [NK-1:0]         pend;
        logic [2:0]            tch_sync;
        logic [2:0]            sw_s1;
        logic [2:0]            sw_s2;
        logic [2:0]            sw_prev;
        logic                  rpt_valid;
        logic [2:0]            rpt_kind;
        logic [31:0]           rpt_data;
        logic [2:0]            range_sel;
        logic [31:0]           gain;
        logic [31:0]           off;
        logic [31:0]           noise;
    } apdc_regs_t;

    apdc_regs_t s_r;
    apdc_regs_t s_nxt;
    logic [31:0] rd_gain;
    logic [31:0] rd_off;
    logic [31:0] rd_noise;

    apdc_cal_store u_cal (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .we_i       (cal_we_i),
        .widx_i     (cal_idx_i),
        .wgain_i    (cal_gain_i),
        .woff_i     (cal_off_i),
        .wnoise_i   (cal_noise_i),
        .ridx_i     (s_r.range_sel),
        .rgain_o    (rd_gain),
        .roff_o     (rd_off),
        .rnoise_o   (rd_noise)
    );

    always_comb
    begin
        logic          tick;
        logic          touch_rise;
        logic          sw_change;
        logic          found;
        logic [NK-1:0] set;
        tick       = (s_r.pre == PRE_LAST);
        touch_rise = s_r.tch_sync[1] & ~s_r.tch_sync[2];
        sw_change  = (s_r.sw_s2 != s_r.sw_prev);
        found      = 1'b0;
        set        = '0;
        s_nxt      = s_r;
        s_nxt.rpt_valid = 1'b0;
        s_nxt.pre = tick ? '0 : s_r.pre + 1'b1;
        s_nxt.tch_sync = {s_r.tch_sync[1:0], touch_i};
        s_nxt.sw_s1   = {mode_sw_i, vrange_sw_i};
        s_nxt.sw_s2   = s_r.sw_s1;
        s_nxt.sw_prev = s_r.sw_s2;
        s_nxt.gain    = rd_gain;
        s_nxt.off     = rd_off;
        s_nxt.noise   = rd_noise;

        case (s_r.st)
            apdc_pkg::APDC_ST_ADV:
            begin
                if (conn_up_i)
                begin
                    s_nxt.st   = apdc_pkg::APDC_ST_CONN;
                    s_nxt.idle = '0;
                    s_nxt.meas = '0;
                    s_nxt.batt = '0;
                    set[apdc_pkg::APDC_K_STATUS] = 1'b1;
                end
                else if (tick)
                begin
                    if (s_r.idle == IDLE_LAST)
                    begin
                        s_nxt.st   = apdc_pkg::APDC_ST_DOWN;
                        s_nxt.idle = '0;
                    end
                    else
                        s_nxt.idle = s_r.idle + 1'b1;
                end
            end
            apdc_pkg::APDC_ST_CONN:
            begin
                s_nxt.idle = '0;
                if (!conn_up_i)
                    s_nxt.st = apdc_pkg::APDC_ST_ADV;
                else
                begin
                    if (tick)
                    begin
                        s_nxt.meas = (s_r.meas == MEAS_LAST) ? '0 : s_r.meas + 1'b1;
                        s_nxt.batt = (s_r.batt == BATT_LAST) ? '0 : s_r.batt + 1'b1;
                        set[apdc_pkg::APDC_K_MEAS_DC] = (s_r.meas == MEAS_LAST);
                        set[apdc_pkg::APDC_K_MEAS_AC] = (s_r.meas == MEAS_LAST);
                        set[apdc_pkg::APDC_K_BATT]    = (s_r.batt == BATT_LAST);
                    end
                    set[apdc_pkg::APDC_K_SWITCH] = sw_change;
                    set[apdc_pkg::APDC_K_TOUCH]  = touch_rise;
                    set[apdc_pkg::APDC_K_NFC]    = nfc_evt_i;
                    if (host_range_we_i)
                        s_nxt.range_sel = host_range_i;
                end
            end
            apdc_pkg::APDC_ST_DOWN:
            begin
                s_nxt.idle = '0;
                // Link requests ignored here; only touch wakes
                if (touch_rise)
                    s_nxt.st = apdc_pkg::APDC_ST_ADV;
            end
            default:
                s_nxt.st = apdc_pkg::APDC_ST_ADV;
        endcase

        // One report per cycle, lowest kind first; a new event wins over the clear
        if (s_r.st == apdc_pkg::APDC_ST_CONN && conn_up_i)
        begin
            for (int k = 0; k < NK; k++)
            begin
                if (!found && s_r.pend[k])
                begin
                    found            = 1'b1;
                    s_nxt.pend[k]    = 1'b0;
                    s_nxt.rpt_valid  = 1'b1;
                    s_nxt.rpt_kind   = 3'(k);
                end
            end
            // Data taken only with a report, so it holds between reports
            if (found)
            begin
                case (s_nxt.rpt_kind)
                    apdc_pkg::APDC_K_MEAS_DC: s_nxt.rpt_data = meas_dc_i;
                    apdc_pkg::APDC_K_MEAS_AC: s_nxt.rpt_data = meas_ac_i;
                    apdc_pkg::APDC_K_BATT:    s_nxt.rpt_data = {8'h00, batt_soc_i, batt_mv_i};
                    apdc_pkg::APDC_K_SWITCH:  s_nxt.rpt_data = {29'h0, s_r.sw_prev};
                    apdc_pkg::APDC_K_STATUS:  s_nxt.rpt_data = {29'h0, s_r.st};
                    default:                  s_nxt.rpt_data = 32'h0;
                endcase
            end
        end

        // Keyed on the next state so the connect status event is not lost
        if (s_nxt.st == apdc_pkg::APDC_ST_CONN)
            s_nxt.pend = s_nxt.pend | set;
        else
            s_nxt.pend = '0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s_r           <= '0;
            s_r.st        <= apdc_pkg::APDC_ST_ADV;
            s_r.range_sel <= 3'h0;
            s_r.gain      <= `APDC_GAIN_MILLI;
        end
        else
            s_r <= s_nxt;
    end

    assign adv_en_o      = s_r.st[0];
    assign conn_accept_o = s_r.st[0];
    assign connected_o   = s_r.st[1];
    assign pwr_down_o    = s_r.st[2];
    assign rpt_valid_o   = s_r.rpt_valid;
    assign rpt_kind_o    = s_r.rpt_kind;
    assign rpt_data_o    = s_r.rpt_data;
    assign range_sel_o   = s_r.range_sel;
    assign cal_gain_o    = s_r.gain;
    assign cal_off_o     = s_r.off;
    assign cal_noise_o   = s_r.noise;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence sq_last_idle_tick;
        s_r.st == apdc_pkg::APDC_ST_ADV && !conn_up_i && s_r.pre == PRE_LAST && s_r.idle == IDLE_LAST;
    endsequence

    a_reset_to_adv: assert property (@(posedge core_clk_i) $fell(rst_i) |-> adv_en_o)
        else $error("not advertising after reset");
    a_idle_expiry: assert property (sq_last_idle_tick |=> pwr_down_o && !adv_en_o)
        else $error("idle expiry did not power down");
    a_idle_bounded: assert property (adv_en_o |-> s_r.idle <= IDLE_LAST)
        else $error("idle counter overran window");
    a_down_silent: assert property (pwr_down_o |-> !adv_en_o && !conn_accept_o && !rpt_valid_o)
        else $error("activity in power-down");
    a_down_exit: assert property ($fell(pwr_down_o) |-> $past(s_r.tch_sync[1] && !s_r.tch_sync[2]))
        else $error("left power-down without touch");
    a_conn_status: assert property ($rose(connected_o) && conn_up_i
        |=> rpt_valid_o && rpt_kind_o == apdc_pkg::APDC_K_STATUS)
        else $error("connect status not reported");
    a_conn_idle_zero: assert property (connected_o |=> s_r.idle == '0)
        else $error("idle counter not held cleared");
    a_meas_pair: assert property (rpt_valid_o && rpt_kind_o == apdc_pkg::APDC_K_MEAS_DC && conn_up_i
        |=> rpt_valid_o && rpt_kind_o == apdc_pkg::APDC_K_MEAS_AC)
        else $error("AC report did not follow DC");
    a_sw_report: assert property (connected_o && conn_up_i && s_r.sw_s2 != s_r.sw_prev && !s_r.pend[0]
        && !s_r.pend[1] && !s_r.pend[2] |=> ##[0:4] rpt_valid_o && rpt_kind_o == apdc_pkg::APDC_K_SWITCH)
        else $error("switch change not reported");
    a_host_range: assert property (connected_o && conn_up_i && host_range_we_i |=> range_sel_o == $past(host_range_i))
        else $error("host range not applied");
    a_cal_update: assert property (cal_we_i && cal_idx_i == range_sel_o && !host_range_we_i
        |=> ##1 cal_gain_o == $past(cal_gain_i, 2))
        else $error("calibration write not used");
endmodule

/* dv/apdc_host_model.sv */
`timescale 1ns/1ps
module apdc_host_model (
    input  wire logic        core_clk_i,
    input  wire logic        rpt_valid_i,
    input  wire logic [2:0]  rpt_kind_i,
    input  wire logic [31:0] rpt_data_i,
    output logic             conn_up_o,
    output logic             range_we_o,
    output logic [2:0]       range_o,
    output logic             cal_we_o,
    output logic [2:0]       cal_idx_o,
    output logic [31:0]      cal_gain_o,
    output logic [31:0]      cal_off_o,
    output logic [31:0]      cal_noise_o
);
    initial
    begin
        conn_up_o   = 1'b0;
        range_we_o  = 1'b0;
        range_o     = 3'h7;
        cal_we_o    = 1'b0;
        cal_idx_o   = 3'h7;
        cal_gain_o  = 32'hffffffff;
        cal_off_o   = 32'hffffffff;
        cal_noise_o = 32'hffffffff;
    end

    task automatic set_link(input logic up);
        @(posedge core_clk_i);
        #1;
        conn_up_o = up;
    endtask

    task automatic send_range(input logic [2:0] r);
        @(posedge core_clk_i);
        #1;
        range_o    = r;
        range_we_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        range_we_o = 1'b0;
        // Released bus shows garbage, never a stale range
        range_o    = ~r;
    endtask

    task automatic send_cal(input logic [2:0] i, input logic [31:0] g, input logic [31:0] o, input logic [31:0] n);
        @(posedge core_clk_i);
        #1;
        cal_idx_o   = i;
        cal_gain_o  = g;
        cal_off_o   = o;
        cal_noise_o = n;
        cal_we_o    = 1'b1;
        @(posedge core_clk_i);
        #1;
        cal_we_o    = 1'b0;
        cal_idx_o   = ~i;
        cal_gain_o  = ~g;
        cal_off_o   = ~o;
        cal_noise_o = ~n;
    endtask

    // Current mode always answers with the 50 mA range
    always @(posedge core_clk_i)
        if (rpt_valid_i === 1'b1 && rpt_kind_i === apdc_pkg::APDC_K_SWITCH)
            send_range(rpt_data_i[2] ? 3'h4 : {1'b0, rpt_data_i[1:0]});
endmodule

/* dv/auto_power_down_ctrl_bench.sv */
`timescale 1ns/1ps
module auto_power_down_ctrl_bench;
    localparam int TC = 4;
    localparam int IT = 20;
    typedef struct packed { logic [2:0] rng; logic [31:0] gain; } apdc_row_t;
    apdc_row_t   rows [6] = '{'{3'h0, 32'h3a83126f}, '{3'h1, 32'h3a83126f}, '{3'h2, 32'h3f800000},
                              '{3'h3, 32'h3f800000}, '{3'h4, 32'h3a83126f}, '{3'h5, 32'h358637bd}};
    logic        core_clk_i = 1'b0;
    logic        rst_i, touch_i, mode_sw_i, nfc_evt_i, conn_up_i, host_range_we_i, cal_we_i;
    logic [1:0]  vrange_sw_i;
    logic [2:0]  host_range_i, cal_idx_i, rpt_kind_o, range_sel_o;
    logic [7:0]  batt_soc_i;
    logic [15:0] batt_mv_i;
    logic [31:0] meas_dc_i, meas_ac_i, cal_gain_i, cal_off_i, cal_noise_i, rpt_data_o, cal_gain_o, cal_off_o;
    logic [31:0] cal_noise_o;
    logic        adv_en_o, conn_accept_o, pwr_down_o, connected_o, rpt_valid_o;
    logic [31:0] last_d [7];
    int          n_kind [7];
    int          n_errors    = 0;
    int          checks_done = 0;
    logic        prev_dc     = 1'b0;

    always #50 core_clk_i = ~core_clk_i;

    apdc_top #(.TICK_CYC(TC), .IDLE_TICKS(IT), .MEAS_TICKS(3), .BATT_TICKS(10)) i_dut (
        .core_clk_i, .rst_i, .touch_i, .vrange_sw_i, .mode_sw_i, .conn_up_i, .nfc_evt_i, .meas_dc_i,
        .meas_ac_i, .batt_soc_i, .batt_mv_i, .host_range_we_i, .host_range_i, .cal_we_i, .cal_idx_i,
        .cal_gain_i, .cal_off_i, .cal_noise_i, .adv_en_o, .conn_accept_o, .pwr_down_o, .connected_o,
        .rpt_valid_o, .rpt_kind_o, .rpt_data_o, .range_sel_o, .cal_gain_o, .cal_off_o, .cal_noise_o);

    apdc_host_model i_host (
        .core_clk_i, .rpt_valid_i(rpt_valid_o), .rpt_kind_i(rpt_kind_o), .rpt_data_i(rpt_data_o),
        .conn_up_o(conn_up_i), .range_we_o(host_range_we_i), .range_o(host_range_i), .cal_we_o(cal_we_i),
        .cal_idx_o(cal_idx_i), .cal_gain_o(cal_gain_i), .cal_off_o(cal_off_i), .cal_noise_o(cal_noise_i));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Report log; an AC report must sit right behind every DC report
    always @(posedge core_clk_i)
    begin
        if (prev_dc)
            chk("ac after dc", 32'h1, 32'(rpt_valid_o === 1'b1 && rpt_kind_o === apdc_pkg::APDC_K_MEAS_AC));
        prev_dc = rpt_valid_o === 1'b1 && rpt_kind_o === apdc_pkg::APDC_K_MEAS_DC;
        if (rpt_valid_o === 1'b1 && rpt_kind_o < 3'h7)
        begin
            n_kind[rpt_kind_o]++;
            last_d[rpt_kind_o] = rpt_data_o;
        end
    end

    initial
    begin
        repeat (4000) @(posedge core_clk_i);
        n_errors++;
        $display("ERROR watchdog expected end seen hang");
        end_of_test();
    end

    initial
    begin
        rst_i       = 1'b1;
        touch_i     = 1'b0;
        mode_sw_i   = 1'b0;
        nfc_evt_i   = 1'b0;
        vrange_sw_i = 2'h0;
        meas_dc_i   = 32'h00001234;
        meas_ac_i   = 32'h00005678;
        batt_soc_i  = 8'h5a;
        batt_mv_i   = 16'h0e74;
        cyc(20);
        rst_i = 1'b0;
        chk("adv_en", 32'h1, {31'h0, adv_en_o});
        chk("conn_accept", 32'h1, {31'h0, conn_accept_o});
        chk("pwr_down", 32'h0, {31'h0, pwr_down_o});
        chk("cal_gain", 32'h3a83126f, cal_gain_o);
        $display("reset test done");
        cyc(IT * TC - 10);
        chk("early pwr_down", 32'h0, {31'h0, pwr_down_o});
        for (int k = 0; k < 40 && pwr_down_o !== 1'b1; k++) cyc(1);
        chk("pwr_down", 32'h1, {31'h0, pwr_down_o});
        chk("adv_en down", 32'h0, {31'h0, adv_en_o});
        chk("conn_accept down", 32'h0, {31'h0, conn_accept_o});
        i_host.set_link(1'b1);
        cyc(4);
        chk("connected down", 32'h0, {31'h0, connected_o});
        touch_i = 1'b1;
        cyc(4);
        touch_i = 1'b0;
        for (int k = 0; k < 10 && adv_en_o !== 1'b1 && connected_o !== 1'b1; k++) cyc(1);
        chk("woken", 32'h0, {31'h0, pwr_down_o});
        cyc(2);
        chk("connected", 32'h1, {31'h0, connected_o});
        chk("status data", {29'h0, apdc_pkg::APDC_ST_CONN}, last_d[6]);
        $display("idle and wake test done");
        n_kind = '{default: 0};
        cyc(IT * TC * 2);
        chk("pwr_down conn", 32'h0, {31'h0, pwr_down_o});
        chk("dc count", 32'h1, 32'(n_kind[0] >= 12 && n_kind[0] <= 14));
        chk("dc data", meas_dc_i, last_d[0]);
        chk("ac data", meas_ac_i, last_d[1]);
        chk("batt count", 32'h1, 32'(n_kind[2] >= 3 && n_kind[2] <= 5));
        chk("batt data", {8'h00, batt_soc_i, batt_mv_i}, last_d[2]);
        nfc_evt_i = 1'b1;
        touch_i   = 1'b1;
        cyc(1);
        nfc_evt_i = 1'b0;
        cyc(4);
        touch_i = 1'b0;
        cyc(10);
        chk("nfc events", 32'h1, n_kind[5]);
        chk("touch events", 32'h1, n_kind[4]);
        $display("stream test done");
        foreach (rows[i])
        begin
            i_host.send_range(rows[i].rng);
            cyc(2);
            chk("range_sel", {29'h0, rows[i].rng}, {29'h0, range_sel_o});
            chk("default gain", rows[i].gain, cal_gain_o);
            chk("default offset", 32'h0, cal_off_o);
            chk("default noise", 32'h0, cal_noise_o);
        end
        i_host.send_cal(3'h5, 32'h40400000, 32'h00000011, 32'h00000022);
        cyc(3);
        chk("new gain", 32'h40400000, cal_gain_o);
        chk("new offset", 32'h00000011, cal_off_o);
        chk("new noise", 32'h00000022, cal_noise_o);
        $display("calibration test done");
        vrange_sw_i = 2'h2;
        cyc(12);
        chk("switch data", 32'h2, {29'h0, last_d[3][2:0]});
        chk("range reply", 32'h2, {29'h0, range_sel_o});
        mode_sw_i = 1'b1;
        cyc(12);
        chk("mode data", 32'h6, {29'h0, last_d[3][2:0]});
        chk("mode reply", 32'h4, {29'h0, range_sel_o});
        $display("switch test done");
        i_host.set_link(1'b0);
        cyc(2);
        chk("advertising again", 32'h1, {31'h0, adv_en_o});
        cyc(IT * TC - 10);
        chk("resumed count", 32'h0, {31'h0, pwr_down_o});
        for (int k = 0; k < 40 && pwr_down_o !== 1'b1; k++) cyc(1);
        chk("pwr_down again", 32'h1, {31'h0, pwr_down_o});
        rst_i = 1'b1;
        cyc(2);
        chk("reset wake", 32'h1, {31'h0, adv_en_o});
        rst_i = 1'b0;
        cyc(1);
        chk("reset range", 32'h0, {29'h0, range_sel_o});
        $display("disconnect and reset test done");
        end_of_test();
    end
endmodule
